/* src/umpaf_params.svh */
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: Included by the package and by every design file except the interface.
// Notes:   Offsets are word indices on the plain software port.
`ifndef UMPAF_PARAMS_SVH
`define UMPAF_PARAMS_SVH

// ----------------------------------------------------------------
// Widths and timing
// ----------------------------------------------------------------
`define UMPAF_AW        3
`define UMPAF_DW        16
`define UMPAF_DIVW      12
`define UMPAF_OVS_NORM  5'h10
`define UMPAF_OVS_DBL   5'h08
`define UMPAF_SIZE_9    3'h7
`define UMPAF_SIZE_RST  3'h3

// ----------------------------------------------------------------
// Device end registers
// ----------------------------------------------------------------
`define UMPAF_DEV_CSA   3'h0
`define UMPAF_DEV_CSB   3'h1
`define UMPAF_DEV_BAUD  3'h2
`define UMPAF_DEV_DATA  3'h3
`define UMPAF_IRQ_STAT  3'h4
`define UMPAF_IRQ_CLR   3'h5
`define UMPAF_IRQ_EN    3'h6
`define UMPAF_CSA_FILT  0
`define UMPAF_CSA_TXC   1
`define UMPAF_CSA_RXC   2
`define UMPAF_CSA_DBL   3
`define UMPAF_CSA_FERR  4
`define UMPAF_CSB_STOP  3
`define UMPAF_CSB_TXN   4
`define UMPAF_CSB_RXN   5
`define UMPAF_EV_RXC    0
`define UMPAF_EV_TXC    1
`define UMPAF_EV_FERR   2
`define UMPAF_EV_N      3

// ----------------------------------------------------------------
// Host end registers
// ----------------------------------------------------------------
`define UMPAF_HST_CFG   3'h0
`define UMPAF_HST_STAT  3'h1
`define UMPAF_HST_BAUD  3'h2
`define UMPAF_HST_SEND  3'h3
`define UMPAF_CFG_DBL   3
`define UMPAF_SEND_MARK 8

`endif

/* src/umpaf_pkg.sv */
// Purpose: Types shared by both ends of the address filtering link.
// Assumes: The constants header is on the include path.
// Notes:   State codes are one-hot.
`include "umpaf_params.svh"
package umpaf_pkg;
    typedef logic [`UMPAF_AW-1:0]   umpaf_addr_t;
    typedef logic [`UMPAF_DW-1:0]   umpaf_data_t;
    typedef logic [`UMPAF_DIVW-1:0] umpaf_div_t;
    typedef enum logic [1:0] {
        UMPAF_TX_IDLE = 2'b01,
        UMPAF_TX_SEND = 2'b10
    } umpaf_tx_state_e;
    typedef enum logic [2:0] {
        UMPAF_RX_IDLE  = 3'b001,
        UMPAF_RX_START = 3'b010,
        UMPAF_RX_BITS  = 3'b100
    } umpaf_rx_state_e;
endpackage : umpaf_pkg

/* src/umpaf_if.sv */
// Purpose: Serial line between the master port and a filtering slave port.
// Assumes: Both lines idle high.
// Notes:   Each party drives only its own transmit line.
`timescale 1ns/10ps
interface umpaf_if;
    logic m2s_txd;
    logic s2m_txd;
    modport dev  (input m2s_txd, output s2m_txd);
    modport host (output m2s_txd);
endinterface : umpaf_if

/* src/umpaf_tx.sv */
// Purpose: Character transmitter with baud divisor and double speed.
// Assumes: Start is honoured only while idle.
// Notes:   Divisor, speed and format are captured when a character starts.
`timescale 1ns/10ps
`include "umpaf_params.svh"
module umpaf_tx (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire umpaf_pkg::umpaf_div_t div_i,
    input  wire logic               dbl_i,
    input  wire logic [2:0]         size_i,
    input  wire logic               two_stop_i,
    input  wire logic               mark_stop_i,
    input  wire logic               start_i,
    input  wire logic [8:0]         data_i,
    output logic                    txd_o,
    output logic                    busy_o,
    output logic                    done_o
);
    import umpaf_pkg::*;

    umpaf_tx_state_e st_q;
    umpaf_div_t      div_q;
    umpaf_div_t      cnt_q;
    logic [4:0]      ovs_max_q;
    logic [4:0]      ovs_q;
    logic [3:0]      left_q;
    logic [11:0]     sh_q;
    logic [11:0]     frame;
    logic [10:0]     ext;
    logic [3:0]      nd;

    // ----------------------------------------------------------------
    // Frame assembly
    // ----------------------------------------------------------------
    always_comb begin
        nd = (size_i == `UMPAF_SIZE_9) ? 4'h9 : 4'h5 + {1'b0, size_i}; // [R7]
        ext = {2'b11, data_i};
        frame[0] = 1'b0;
        for (int i = 0; i < 11; i++) begin
            if (4'(i) < nd) begin
                frame[i+1] = ext[i]; // [R1]
            end else if (4'(i) == nd && mark_stop_i && size_i != `UMPAF_SIZE_9) begin
                // A 9-bit frame keeps its stop bit high, the ninth bit is the marker.
                frame[i+1] = data_i[8]; // [R8]
            end else begin
                frame[i+1] = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Shifter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            st_q      <= UMPAF_TX_IDLE;
            sh_q      <= 12'hFFF;
            div_q     <= '0;
            cnt_q     <= '0;
            ovs_q     <= 5'h00;
            ovs_max_q <= `UMPAF_OVS_NORM;
            left_q    <= 4'h0;
        end else begin
            case (st_q)
                UMPAF_TX_IDLE: begin
                    if (start_i) begin
                        sh_q      <= frame;
                        left_q    <= 4'h2 + nd + {3'h0, two_stop_i};
                        div_q     <= div_i;
                        cnt_q     <= '0;
                        ovs_q     <= 5'h00;
                        ovs_max_q <= dbl_i ? `UMPAF_OVS_DBL : `UMPAF_OVS_NORM; // [R13]
                        st_q      <= UMPAF_TX_SEND;
                    end
                end
                UMPAF_TX_SEND: begin
                    // Zero divisor ticks every clock, the fastest rate. [R10]
                    if (cnt_q == div_q) begin
                        cnt_q <= '0;
                        if (ovs_q == ovs_max_q - 5'h01) begin
                            ovs_q  <= 5'h00;
                            sh_q   <= {1'b1, sh_q[11:1]};
                            left_q <= left_q - 4'h1;
                            if (left_q == 4'h1) begin
                                st_q   <= UMPAF_TX_IDLE;
                                done_o <= 1'b1;
                            end
                        end else begin
                            ovs_q <= ovs_q + 5'h01;
                        end
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: st_q <= UMPAF_TX_IDLE;
            endcase
        end
    end

    assign txd_o  = sh_q[0];
    assign busy_o = (st_q == UMPAF_TX_SEND);
endmodule : umpaf_tx

/* src/umpaf_dev.sv */
// Purpose: Slave serial port with multi-processor address filtering.
// Assumes: Software uses the plain register port; the line idles high.
// Notes:   Receive and transmit share one character size setting.
// How it works
// R1: Transmitter sends ninth bit as marker.
// R2: Slaves use 9-bit format with 9-bit master.
// R3: Address frame stored, sets receive complete.
// R4: Software clears filter after matching address.
// R5: Filtered receiver drops data frames.
// R6: Software re-arms filter after last frame.
// R7: One character size for both directions.
// R8: Master uses two stops for 5-8 bits.
// R9: Filter bit shares word with transmit flag.
// R10: Divisor zero gives fastest rate.
// R11: Marker is first stop or ninth bit.
// R12: Filter drops data; transmitter unaffected.
// R13: Rate is clock over 16 or 8 times divisor plus one.
`timescale 1ns/10ps
`include "umpaf_params.svh"
module umpaf_dev (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    umpaf_if.dev                        line,
    input  wire umpaf_pkg::umpaf_addr_t addr_i,
    input  wire umpaf_pkg::umpaf_data_t wdata_i,
    input  wire logic                   we_i,
    input  wire logic                   re_i,
    output umpaf_pkg::umpaf_data_t      rdata_o,
    output logic                        irq_o
);
    import umpaf_pkg::*;

    logic                  filt_q;
    logic                  txc_q;
    logic                  rxc_q;
    logic                  ferr_q;
    logic                  dbl_q;
    logic [2:0]            size_q;
    logic                  stop_q;
    logic                  txn_q;
    umpaf_div_t            div_q;
    logic [7:0]            rxd_q;
    logic                  rxn_q;
    logic [`UMPAF_EV_N-1:0] ist_q;
    logic [`UMPAF_EV_N-1:0] ien_q;
    logic [`UMPAF_EV_N-1:0] ev;
    umpaf_data_t           rd_q;
    logic                  s1_q;
    logic                  s2_q;
    umpaf_rx_state_e       st_q;
    umpaf_div_t            cnt_q;
    logic [4:0]            ovs_q;
    logic [3:0]            idx_q;
    logic [9:0]            sh_q;
    logic [4:0]            ovs_max;
    logic [3:0]            nd;
    logic                  tick;
    logic                  fin;
    logic                  mark;
    logic                  accept;
    logic                  tx_busy;
    logic                  tx_done;
    logic                  tx_start;
    logic                  wr_csa;
    logic                  rd_data;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    assign wr_csa   = we_i && (addr_i == `UMPAF_DEV_CSA);
    assign rd_data  = re_i && (addr_i == `UMPAF_DEV_DATA);
    assign tx_start = we_i && (addr_i == `UMPAF_DEV_DATA) && !tx_busy;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filt_q <= 1'b0;
            dbl_q  <= 1'b0;
            size_q <= `UMPAF_SIZE_RST;
            stop_q <= 1'b0;
            txn_q  <= 1'b0;
            div_q  <= '0;
            ien_q  <= '0;
        end else if (wr_csa) begin
            // The filter bit and the transmit flag share this word; writing
            // a one back to the flag clears it, so blind read-modify-write
            // from software can lose a pending flag. [R9]
            filt_q <= wdata_i[`UMPAF_CSA_FILT]; // [R4]
            dbl_q  <= wdata_i[`UMPAF_CSA_DBL];
        end else if (we_i && addr_i == `UMPAF_DEV_CSB) begin
            size_q <= wdata_i[2:0]; // [R7]
            stop_q <= wdata_i[`UMPAF_CSB_STOP];
            txn_q  <= wdata_i[`UMPAF_CSB_TXN]; // [R1]
        end else if (we_i && addr_i == `UMPAF_DEV_BAUD) begin
            div_q  <= wdata_i[`UMPAF_DIVW-1:0];
        end else if (we_i && addr_i == `UMPAF_IRQ_EN) begin
            ien_q  <= wdata_i[`UMPAF_EV_N-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Flags, set wins over clear
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txc_q <= 1'b0;
            rxc_q <= 1'b0;
        end else begin
            txc_q <= tx_done | (txc_q & ~(wr_csa & wdata_i[`UMPAF_CSA_TXC])); // [R9]
            rxc_q <= accept | (rxc_q & ~rd_data); // [R3]
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    assign ev[`UMPAF_EV_RXC]  = accept;
    assign ev[`UMPAF_EV_TXC]  = tx_done;
    assign ev[`UMPAF_EV_FERR] = accept & ~s2_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ist_q <= '0;
        end else if (we_i && addr_i == `UMPAF_IRQ_CLR) begin
            ist_q <= ev | (ist_q & ~wdata_i[`UMPAF_EV_N-1:0]);
        end else begin
            ist_q <= ev | ist_q;
        end
    end

    assign irq_o = |(ist_q & ien_q);

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_q <= '0;
        end else if (!re_i) begin
            rd_q <= '0;
        end else if (addr_i == `UMPAF_DEV_CSA) begin
            rd_q <= {11'h000, ferr_q, dbl_q, rxc_q, txc_q, filt_q};
        end else if (addr_i == `UMPAF_DEV_CSB) begin
            rd_q <= {10'h000, rxn_q, txn_q, stop_q, size_q};
        end else if (addr_i == `UMPAF_DEV_BAUD) begin
            rd_q <= {4'h0, div_q};
        end else if (addr_i == `UMPAF_DEV_DATA) begin
            rd_q <= {8'h00, rxd_q};
        end else if (addr_i == `UMPAF_IRQ_STAT) begin
            rd_q <= {13'h0000, ist_q};
        end else if (addr_i == `UMPAF_IRQ_EN) begin
            rd_q <= {13'h0000, ien_q};
        end else begin
            rd_q <= '0;
        end
    end

    assign rdata_o = rd_q;

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
        end else begin
            s1_q <= line.m2s_txd;
            s2_q <= s1_q;
        end
    end

    assign ovs_max = dbl_q ? `UMPAF_OVS_DBL : `UMPAF_OVS_NORM; // [R13]
    assign nd      = (size_q == `UMPAF_SIZE_9) ? 4'h9 : 4'h5 + {1'b0, size_q}; // [R2]
    assign tick    = (cnt_q == div_q); // [R10]
    assign fin     = (st_q == UMPAF_RX_BITS) && tick
                     && (ovs_q == ovs_max - 5'h01) && (idx_q == nd);
    // Ninth bit in 9-bit format, otherwise the first stop bit. [R11]
    assign mark    = (size_q == `UMPAF_SIZE_9) ? sh_q[8] : s2_q;
    assign accept  = fin && (!filt_q || mark); // [R5] [R12]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q  <= UMPAF_RX_IDLE;
            cnt_q <= '0;
            ovs_q <= 5'h00;
            idx_q <= 4'h0;
            sh_q  <= '0;
        end else begin
            cnt_q <= (tick || st_q == UMPAF_RX_IDLE) ? '0 : cnt_q + 1'b1;
            case (st_q)
                UMPAF_RX_IDLE: begin
                    ovs_q <= 5'h00;
                    if (!s2_q) begin
                        sh_q <= '0;
                        st_q <= UMPAF_RX_START;
                    end
                end
                UMPAF_RX_START: begin
                    if (tick) begin
                        if (ovs_q == (ovs_max >> 1) - 5'h01) begin
                            // A glitch shorter than half a bit is not a start.
                            ovs_q <= 5'h00;
                            idx_q <= 4'h0;
                            st_q  <= s2_q ? UMPAF_RX_IDLE : UMPAF_RX_BITS;
                        end else begin
                            ovs_q <= ovs_q + 5'h01;
                        end
                    end
                end
                UMPAF_RX_BITS: begin
                    if (tick) begin
                        if (ovs_q == ovs_max - 5'h01) begin
                            ovs_q       <= 5'h00;
                            sh_q[idx_q] <= s2_q;
                            idx_q       <= idx_q + 4'h1;
                            if (idx_q == nd) begin
                                st_q <= UMPAF_RX_IDLE;
                            end
                        end else begin
                            ovs_q <= ovs_q + 5'h01;
                        end
                    end
                end
                default: st_q <= UMPAF_RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxd_q  <= 8'h00;
            rxn_q  <= 1'b0;
            ferr_q <= 1'b0;
        end else if (accept) begin
            rxd_q  <= sh_q[7:0]; // [R3]
            rxn_q  <= sh_q[8];
            ferr_q <= ~s2_q;
        end
    end

    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    umpaf_tx i_umpaf_tx (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .div_i       (div_q),
        .dbl_i       (dbl_q),
        .size_i      (size_q),
        .two_stop_i  (stop_q),
        .mark_stop_i (1'b0),
        .start_i     (tx_start),
        .data_i      ({txn_q, wdata_i[7:0]}),
        .txd_o       (line.s2m_txd),
        .busy_o      (tx_busy),
        .done_o      (tx_done)
    );
endmodule : umpaf_dev

/* src/umpaf_host.sv */
// Purpose: Master serial port that tags characters as address or data.
// Assumes: Software uses the plain register port.
// Notes:   In 5 to 8 bit formats the marker rides in the first stop bit.
`timescale 1ns/10ps
`include "umpaf_params.svh"
module umpaf_host (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    umpaf_if.host                       line,
    input  wire umpaf_pkg::umpaf_addr_t addr_i,
    input  wire umpaf_pkg::umpaf_data_t wdata_i,
    input  wire logic                   we_i,
    input  wire logic                   re_i,
    output umpaf_pkg::umpaf_data_t      rdata_o,
    output logic                        irq_o
);
    import umpaf_pkg::*;

    logic [2:0]  size_q;
    logic        dbl_q;
    umpaf_div_t  div_q;
    logic        ist_q;
    logic        ien_q;
    umpaf_data_t rd_q;
    logic        busy;
    logic        done;
    logic        start;

    assign start = we_i && (addr_i == `UMPAF_HST_SEND) && !busy;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            size_q <= `UMPAF_SIZE_9;
            dbl_q  <= 1'b0;
            div_q  <= '0;
            ien_q  <= 1'b0;
        end else if (we_i && addr_i == `UMPAF_HST_CFG) begin
            size_q <= wdata_i[2:0];
            dbl_q  <= wdata_i[`UMPAF_CFG_DBL];
        end else if (we_i && addr_i == `UMPAF_HST_BAUD) begin
            div_q  <= wdata_i[`UMPAF_DIVW-1:0];
        end else if (we_i && addr_i == `UMPAF_IRQ_EN) begin
            ien_q  <= wdata_i[`UMPAF_EV_TXC];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ist_q <= 1'b0;
        end else begin
            ist_q <= done | (ist_q & ~(we_i && addr_i == `UMPAF_IRQ_CLR
                                       && wdata_i[`UMPAF_EV_TXC]));
        end
    end

    assign irq_o = ist_q & ien_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || !re_i) begin
            rd_q <= '0;
        end else if (addr_i == `UMPAF_HST_CFG) begin
            rd_q <= {12'h000, dbl_q, size_q};
        end else if (addr_i == `UMPAF_HST_STAT) begin
            rd_q <= {15'h0000, busy};
        end else if (addr_i == `UMPAF_HST_BAUD) begin
            rd_q <= {4'h0, div_q};
        end else if (addr_i == `UMPAF_IRQ_STAT) begin
            rd_q <= {14'h0000, ist_q, 1'b0};
        end else if (addr_i == `UMPAF_IRQ_EN) begin
            rd_q <= {14'h0000, ien_q, 1'b0};
        end else begin
            rd_q <= '0;
        end
    end

    assign rdata_o = rd_q;

    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    // Two stops in 5 to 8 bit formats: the first carries the marker. [R8]
    umpaf_tx i_umpaf_tx (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .div_i       (div_q),
        .dbl_i       (dbl_q),
        .size_i      (size_q),
        .two_stop_i  (size_q != `UMPAF_SIZE_9),
        .mark_stop_i (1'b1),
        .start_i     (start),
        .data_i      (wdata_i[8:0]),
        .txd_o       (line.m2s_txd),
        .busy_o      (busy),
        .done_o      (done)
    );
endmodule : umpaf_host

/* dv/umpaf_checker.sv */
// Purpose: Timing checks on the serial lines and the device register port.
// Assumes: The bench writes device data only while its transmitter is idle.
// Notes:   Eight clocks is the shortest bit, so line edges are that far apart.
`timescale 1ns/10ps
`include "umpaf_params.svh"
module umpaf_checker (
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire logic                   m2s_txd,
    input wire logic                   s2m_txd,
    input wire umpaf_pkg::umpaf_addr_t addr_i,
    input wire umpaf_pkg::umpaf_data_t wdata_i,
    input wire logic                   we_i,
    input wire logic                   re_i,
    input wire umpaf_pkg::umpaf_data_t rdata_o,
    input wire logic                   irq_o
);
    import umpaf_pkg::*;
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_m2s_bit; $changed(m2s_txd) |=> $stable(m2s_txd) [*7]; endproperty
    a_m2s_bit: assert property (p_m2s_bit) else $error("master bit too short");
    property p_s2m_bit; $changed(s2m_txd) |=> $stable(s2m_txd) [*7]; endproperty
    a_s2m_bit: assert property (p_s2m_bit) else $error("slave bit too short");
    property p_rd_zero; !$past(re_i) |-> rdata_o == 16'h0000; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
    property p_unmapped; re_i && addr_i == 3'h7 |=> rdata_o == 16'h0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_irq_clr;
        we_i && addr_i == `UMPAF_IRQ_CLR && wdata_i[2:0] == 3'h7 |=> !irq_o;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq stays after clear");
    property p_irq_en0; we_i && addr_i == `UMPAF_IRQ_EN && wdata_i == 16'h0000 |=> !irq_o;
    endproperty
    a_irq_en0: assert property (p_irq_en0) else $error("irq while disabled");
    property p_tx_start; we_i && addr_i == `UMPAF_DEV_DATA |=> ##[0:2] !s2m_txd; endproperty
    a_tx_start: assert property (p_tx_start) else $error("no start bit");
    property p_start_len; $fell(s2m_txd) |-> !s2m_txd [*8]; endproperty
    a_start_len: assert property (p_start_len) else $error("start bit short");
endmodule : umpaf_checker

/* dv/umpaf_test.sv */
// Purpose: Address filtering between the master and slave ports.
// Assumes: Both ends share one clock and one serial interface.
// Notes:   Frame waits use the fixed bit time of divisor zero.
`timescale 1ns/10ps
`include "umpaf_params.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module umpaf_test;
    import umpaf_pkg::*;
    // ----------------------------------------------------------------
    // Harness
    // ----------------------------------------------------------------
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        d_we = 1'b0, d_re = 1'b0, h_we = 1'b0, h_re = 1'b0, d_irq, h_irq;
    umpaf_addr_t d_addr = 3'h0, h_addr = 3'h0;
    umpaf_data_t d_wd = 16'h0000, h_wd = 16'h0000, d_rd, h_rd;
    int          errors = 0, checks = 0, cyc = 0;
    logic [10:0] ex;
    umpaf_if i_umpaf_if ();
    umpaf_dev i_umpaf_dev (.clk_i(clk_i), .rst_i(rst_i), .line(i_umpaf_if), .addr_i(d_addr),
        .wdata_i(d_wd), .we_i(d_we), .re_i(d_re), .rdata_o(d_rd), .irq_o(d_irq));
    umpaf_host i_umpaf_host (.clk_i(clk_i), .rst_i(rst_i), .line(i_umpaf_if), .addr_i(h_addr),
        .wdata_i(h_wd), .we_i(h_we), .re_i(h_re), .rdata_o(h_rd), .irq_o(h_irq));
    umpaf_checker i_umpaf_checker (.clk_i(clk_i), .rst_i(rst_i),
        .m2s_txd(i_umpaf_if.m2s_txd), .s2m_txd(i_umpaf_if.s2m_txd), .addr_i(d_addr),
        .wdata_i(d_wd), .we_i(d_we), .re_i(d_re), .rdata_o(d_rd), .irq_o(d_irq));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            finish_test();
        end
    end
    task automatic wr(input logic h, input umpaf_addr_t a, input umpaf_data_t d);
        @(posedge clk_i);
        if (h) begin h_addr <= a; h_wd <= d; h_we <= 1'b1; end
        else begin d_addr <= a; d_wd <= d; d_we <= 1'b1; end
        @(posedge clk_i);
        h_we <= 1'b0;
        d_we <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic h, input umpaf_addr_t a, input umpaf_data_t e, input string nm);
        @(posedge clk_i);
        if (h) begin h_addr <= a; h_re <= 1'b1; end
        else begin d_addr <= a; d_re <= 1'b1; end
        @(posedge clk_i);
        h_re <= 1'b0;
        d_re <= 1'b0;
        #1 `CHK(nm, e, h ? h_rd : d_rd)
    endtask : rd
    // The wait covers twelve bits of sixteen clocks plus the receiver's sync.
    task automatic frame(input logic [8:0] v);
        wr(1'b1, `UMPAF_HST_SEND, {7'h00, v});
        repeat (12 * 16 + 8) @(posedge clk_i);
    endtask : frame
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(1'b0, `UMPAF_DEV_CSA, 16'h0000, "csa");
        rd(1'b0, `UMPAF_DEV_CSB, 16'h0003, "csb");
        rd(1'b0, `UMPAF_DEV_BAUD, 16'h0000, "baud");
        rd(1'b0, 3'h7, 16'h0000, "unmapped");
        rd(1'b1, `UMPAF_HST_CFG, 16'h0007, "host cfg");
        $display("test reset done");
        wr(1'b0, `UMPAF_DEV_CSB, 16'h0007);
        wr(1'b0, `UMPAF_IRQ_EN, 16'h0001);
        wr(1'b0, `UMPAF_DEV_CSA, 16'h0001);
        frame(9'h0AA);
        rd(1'b0, `UMPAF_DEV_CSA, 16'h0001, "csa drop");
        `CHK("irq drop", 1'b0, d_irq)
        frame(9'h142);
        rd(1'b0, `UMPAF_DEV_CSA, 16'h0005, "csa addr");
        `CHK("irq addr", 1'b1, d_irq)
        rd(1'b0, `UMPAF_DEV_CSB, 16'h0027, "ninth");
        rd(1'b0, `UMPAF_DEV_DATA, 16'h0042, "addr byte");
        rd(1'b0, `UMPAF_DEV_CSA, 16'h0001, "rxc clear");
        wr(1'b0, `UMPAF_DEV_CSA, 16'h0000);
        frame(9'h033);
        rd(1'b0, `UMPAF_DEV_DATA, 16'h0033, "data byte");
        wr(1'b0, `UMPAF_IRQ_CLR, 16'h0007);
        `CHK("irq clear", 1'b0, d_irq)
        wr(1'b0, `UMPAF_DEV_CSA, 16'h0001);
        frame(9'h055);
        rd(1'b0, `UMPAF_DEV_DATA, 16'h0033, "rearmed");
        rd(1'b0, `UMPAF_IRQ_STAT, 16'h0000, "no event");
        wr(1'b1, `UMPAF_HST_CFG, 16'h0003);
        wr(1'b0, `UMPAF_DEV_CSB, 16'h0003);
        frame(9'h1C3);
        rd(1'b0, `UMPAF_DEV_DATA, 16'h00C3, "stop mark");
        rd(1'b1, `UMPAF_IRQ_STAT, 16'h0002, "host done");
        wr(1'b1, `UMPAF_IRQ_EN, 16'h0002);
        `CHK("host irq", 1'b1, h_irq)
        wr(1'b1, `UMPAF_IRQ_CLR, 16'h0002);
        `CHK("host irq clear", 1'b0, h_irq)
        $display("test filter done");
        ex = {2'b11, 8'hA5, 1'b0};
        for (int sp = 0; sp < 2; sp++) begin
            wr(1'b0, `UMPAF_DEV_CSB, 16'h0017);
            wr(1'b0, `UMPAF_DEV_CSA, sp ? 16'h0009 : 16'h0001);
            wr(1'b0, `UMPAF_DEV_DATA, 16'h00A5);
            for (int i = 0; i < 20 && i_umpaf_if.s2m_txd; i++) @(posedge clk_i);
            repeat (sp ? 4 : 8) @(posedge clk_i);
            for (int b = 0; b < 11; b++) begin
                `CHK("slave bit", ex[b], i_umpaf_if.s2m_txd)
                repeat (sp ? 8 : 16) @(posedge clk_i);
            end
        end
        wr(1'b0, `UMPAF_IRQ_EN, 16'h0002);
        `CHK("irq tx", 1'b1, d_irq)
        wr(1'b0, `UMPAF_IRQ_EN, 16'h0000);
        `CHK("irq masked", 1'b0, d_irq)
        $display("test transmit done");
        finish_test();
    end
endmodule : umpaf_test
